// >>> design/card_clock_monitor.sv
// Card clock sampler that flags a stopped or slowed card clock
`timescale 1ns/100ps
module card_clock_monitor #(
	parameter int GAP_LIMIT = socket_pm_pkg::CARD_GAP_LIMIT_CYC
)(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic card_clk,
	output logic rate_changed
);

	// ------------------------------------------------------------
	// Two-stage sampler, then edge finder on the second stage
	// ------------------------------------------------------------
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;
	logic [7:0] gap_ff;
	logic rate_changed_ff;
	logic rise;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			meta_ff <= card_clk;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign rise = sync_ff & ~prev_ff;

	// ------------------------------------------------------------
	// Gap counter
	// ------------------------------------------------------------
	// Counter saturates so a clock stopped for long never wraps back
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			gap_ff <= 8'h00;
		else if (clk_en)
		begin
			if (rise)
				gap_ff <= 8'h00;
			else if (gap_ff != 8'hFF)
				gap_ff <= gap_ff + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			rate_changed_ff <= 1'b0;
		else if (clk_en)
		begin
			// A fresh edge wins, else the stale gap count holds the flag
			if (rise)
				rate_changed_ff <= 1'b0;
			else if (gap_ff >= 8'(GAP_LIMIT))
				rate_changed_ff <= 1'b1;
		end
	end

	assign rate_changed = rate_changed_ff;

endmodule

// >>> design/socket_pm_pkg.sv
// Constants shared by the socket supply and idle clock control block
package socket_pm_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_SUPPLY_POLICY = 8'h10;
	localparam logic [7:0] OFS_IDLE_CLOCK = 8'h20;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h40;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h44;

	// ------------------------------------------------------------
	// Supply and policy register fields
	// ------------------------------------------------------------
	localparam int VPP_LSB = 0;
	localparam int VPP_W = 3;
	localparam int VCC_LSB = 4;
	localparam int VCC_W = 3;
	localparam int HALT_POLICY_BIT = 7;
	localparam logic [2:0] VPP_OFF = 3'h0;
	localparam logic [2:0] VPP_12V = 3'h1;
	localparam logic [2:0] VPP_5V = 3'h2;
	localparam logic [2:0] VPP_3V3 = 3'h3;
	localparam logic [2:0] VPP_ALT_X = 3'h4;
	localparam logic [2:0] VPP_ALT_Y = 3'h5;
	localparam logic [2:0] VCC_OFF = 3'h0;

	// ------------------------------------------------------------
	// Idle clock register fields
	// ------------------------------------------------------------
	localparam int HALT_SLOW_BIT = 0;
	localparam int GATE_ENABLE_BIT = 16;
	localparam int RATE_CHANGED_BIT = 24;
	localparam int ACCESS_SEEN_BIT = 25;

	// ------------------------------------------------------------
	// Event status bits
	// ------------------------------------------------------------
	localparam int NUM_EVENTS = 4;
	localparam int EV_ACCESS = 0;
	localparam int EV_RATE_DROP = 1;
	localparam int EV_RATE_BACK = 2;
	localparam int EV_RETEST_DONE = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_SUPPLY_POLICY = 32'h0000_0000;
	localparam logic [31:0] RST_IDLE_CLOCK = 32'h0000_0000;
	localparam logic [3:0] RST_EVENT_MASK = 4'h0;

	// ------------------------------------------------------------
	// Timing of the card clock monitor
	// ------------------------------------------------------------
	localparam int SYS_CLK_PS = 5000;
	localparam int CARD_CLK_NOMINAL_PS = 80000;
	// A gap of twice the nominal period counts as stopped or slowed
	localparam int CARD_GAP_LIMIT_CYC = (2 * CARD_CLK_NOMINAL_PS) / SYS_CLK_PS;

	// ------------------------------------------------------------
	// Supply control states, Gray along enabled-locked-retest
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SUP_ENABLED = 2'b00,
		SUP_LOCKED = 2'b01,
		SUP_RETEST = 2'b11
	} supply_state_t;

endpackage

// >>> design/socket_power_clock_control.sv
// Socket supply request and idle card clock policy registers
//
// Function
// - Power reaches the socket only at levels the inserted card accepts.
// - With the halt policy at 0, idle halt needs an idle socket and a host clock about to stop.
// - With the halt policy at 1 and the gate enable at 1, an idle socket alone permits halting or slowing.
// - The program voltage field decodes off, 12 V, 5 V, 3.3 V, two alternates and reserved.
// - Bits 31 to 8 and bit 3 of the supply register ignore writes and read zero.
// - The access flag at bit 25 sets once any card access has happened and resets to 0.
// - A read of the idle clock register clears the access flag unless a card access comes in the same cycle; the flag cannot be written.
// - Bit 24 reads 1 while the card clock is stopped or slowed, 0 while it runs normally.
// - The gate enable at bit 16 gates the halt-or-slow select; at 0 clock control is off.
// - Select bit 0 at 0 permits halting the card clock, at 1 slowing it by 16.
// - Bits 31 to 26, 23 to 17 and 15 to 1 of the idle clock register ignore writes, read 0.
// - A card voltage retest starts re-interrogation; interrogation done then re-enables the supply register.
// - A forced card voltage type disables the supply register until re-interrogation.
`timescale 1ns/100ps
module socket_power_clock_control #(
	parameter int GAP_LIMIT = socket_pm_pkg::CARD_GAP_LIMIT_CYC
)(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic card_clk,
	input wire logic card_present,
	input wire logic card_is_cardbus,
	input wire logic [7:0] vpp_levels_ok,
	input wire logic [7:0] vcc_levels_ok,
	input wire logic card_access,
	input wire logic socket_idle,
	input wire logic host_clk_stopping,
	input wire logic force_voltage_type,
	input wire logic card_voltage_retest,
	input wire logic interrogation_done,
	output logic interrogation_start,
	output logic [2:0] vpp_apply,
	output logic [2:0] vcc_apply,
	output logic supply_enabled,
	output logic clkrun_halt_permit,
	output logic clkrun_slow_permit,
	output logic irq
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] addr,
		input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	// Reserved program voltage codes are never allowed to the switch
	function automatic logic level_ok(input logic [2:0] code,
		input logic [7:0] ok_map, input logic vpp_field);
		logic reserved;
		reserved = vpp_field && (code > socket_pm_pkg::VPP_ALT_Y);
		level_ok = !reserved && ok_map[code];
	endfunction

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [2:0] vpp_req_ff;
	logic [2:0] vcc_req_ff;
	logic halt_policy_ff;
	logic gate_enable_ff;
	logic halt_slow_ff;
	logic access_seen_ff;
	logic rate_changed_prev_ff;
	logic [socket_pm_pkg::NUM_EVENTS-1:0] ev_status_ff;
	logic [socket_pm_pkg::NUM_EVENTS-1:0] ev_mask_ff;
	logic [socket_pm_pkg::NUM_EVENTS-1:0] ev_set;
	logic [31:0] reg_rdata_ff;
	logic [31:0] nxt_rdata;
	logic [2:0] vpp_apply_ff;
	logic [2:0] vcc_apply_ff;
	logic start_ff;
	logic clock_rate_changed;
	logic wr_supply;
	logic wr_idle;
	logic wr_status;
	logic wr_mask;
	logic rd_idle;
	logic ctrl_allowed;
	socket_pm_pkg::supply_state_t state_ff;
	socket_pm_pkg::supply_state_t nxt_state;

	assign wr_supply = reg_wr && hit(reg_addr,
		socket_pm_pkg::OFS_SUPPLY_POLICY);
	assign wr_idle = reg_wr && hit(reg_addr, socket_pm_pkg::OFS_IDLE_CLOCK);
	assign wr_status = reg_wr && hit(reg_addr,
		socket_pm_pkg::OFS_EVENT_STATUS);
	assign wr_mask = reg_wr && hit(reg_addr, socket_pm_pkg::OFS_EVENT_MASK);
	assign rd_idle = reg_rd && hit(reg_addr, socket_pm_pkg::OFS_IDLE_CLOCK);

	// ------------------------------------------------------------
	// Card clock monitor
	// ------------------------------------------------------------
	card_clock_monitor #(
		.GAP_LIMIT(GAP_LIMIT)
	) u_monitor (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.card_clk(card_clk),
		.rate_changed(clock_rate_changed)
	);

	// ------------------------------------------------------------
	// Supply register lock state
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			socket_pm_pkg::SUP_ENABLED:
			begin
				if (card_voltage_retest)
					nxt_state = socket_pm_pkg::SUP_RETEST;
				else if (force_voltage_type)
					nxt_state = socket_pm_pkg::SUP_LOCKED;
			end
			socket_pm_pkg::SUP_LOCKED:
			begin
				if (card_voltage_retest)
					nxt_state = socket_pm_pkg::SUP_RETEST;
			end
			socket_pm_pkg::SUP_RETEST:
			begin
				if (interrogation_done)
					nxt_state = socket_pm_pkg::SUP_ENABLED;
			end
			default:
				nxt_state = socket_pm_pkg::SUP_ENABLED;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			state_ff <= socket_pm_pkg::SUP_ENABLED;
		else if (clk_en)
			state_ff <= nxt_state;
	end

	// One pulse per retest request to the interrogation logic
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			start_ff <= 1'b0;
		else if (clk_en)
			start_ff <= card_voltage_retest;
	end

	assign interrogation_start = start_ff;
	assign supply_enabled = (state_ff == socket_pm_pkg::SUP_ENABLED);

	// ------------------------------------------------------------
	// Supply and policy register
	// ------------------------------------------------------------
	// Writes while locked are dropped, so a forced type cannot race power
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			vpp_req_ff <= socket_pm_pkg::RST_SUPPLY_POLICY[2:0];
			vcc_req_ff <= socket_pm_pkg::RST_SUPPLY_POLICY[6:4];
			halt_policy_ff <= socket_pm_pkg::RST_SUPPLY_POLICY[7];
		end
		else if (clk_en && wr_supply && supply_enabled)
		begin
			vpp_req_ff <= reg_wdata[socket_pm_pkg::VPP_LSB +:
				socket_pm_pkg::VPP_W];
			vcc_req_ff <= reg_wdata[socket_pm_pkg::VCC_LSB +:
				socket_pm_pkg::VCC_W];
			halt_policy_ff <= reg_wdata[socket_pm_pkg::HALT_POLICY_BIT];
		end
	end

	// ------------------------------------------------------------
	// Power switch requests
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			vpp_apply_ff <= socket_pm_pkg::VPP_OFF;
			vcc_apply_ff <= socket_pm_pkg::VCC_OFF;
		end
		else if (clk_en)
		begin
			// only accepted levels reach the card
			if (card_present && card_is_cardbus && supply_enabled &&
				level_ok(vpp_req_ff, vpp_levels_ok, 1'b1))
				vpp_apply_ff <= vpp_req_ff;
			else
				vpp_apply_ff <= socket_pm_pkg::VPP_OFF;
			if (card_present && card_is_cardbus && supply_enabled &&
				level_ok(vcc_req_ff, vcc_levels_ok, 1'b0))
				vcc_apply_ff <= vcc_req_ff;
			else
				vcc_apply_ff <= socket_pm_pkg::VCC_OFF;
		end
	end

	assign vpp_apply = vpp_apply_ff;
	assign vcc_apply = vcc_apply_ff;

	// ------------------------------------------------------------
	// Idle clock register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gate_enable_ff <= socket_pm_pkg::RST_IDLE_CLOCK[16];
			halt_slow_ff <= socket_pm_pkg::RST_IDLE_CLOCK[0];
		end
		else if (clk_en && wr_idle)
		begin
			// only bits 16 and 0 take writes
			gate_enable_ff <= reg_wdata[socket_pm_pkg::GATE_ENABLE_BIT];
			halt_slow_ff <= reg_wdata[socket_pm_pkg::HALT_SLOW_BIT];
		end
	end

	// Access seen: set wins over the read that clears it
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			access_seen_ff <= 1'b0;
		else if (clk_en)
		begin
			if (card_access)
				access_seen_ff <= 1'b1;
			else if (rd_idle)
				access_seen_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Clock run permits
	// ------------------------------------------------------------
	// policy 0 also needs host clock stopping
	// policy 1 needs only the gate enable and an idle socket
	assign ctrl_allowed = gate_enable_ff && socket_idle &&
		(halt_policy_ff || host_clk_stopping);
	// select 0 halts, 1 slows by 16
	assign clkrun_halt_permit = ctrl_allowed && !halt_slow_ff;
	assign clkrun_slow_permit = ctrl_allowed && halt_slow_ff;

	// ------------------------------------------------------------
	// Event status and interrupt
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			rate_changed_prev_ff <= 1'b0;
		else if (clk_en)
			rate_changed_prev_ff <= clock_rate_changed;
	end

	assign ev_set[socket_pm_pkg::EV_ACCESS] = card_access;
	assign ev_set[socket_pm_pkg::EV_RATE_DROP] = clock_rate_changed &&
		!rate_changed_prev_ff;
	assign ev_set[socket_pm_pkg::EV_RATE_BACK] = !clock_rate_changed &&
		rate_changed_prev_ff;
	assign ev_set[socket_pm_pkg::EV_RETEST_DONE] = interrogation_done &&
		(state_ff == socket_pm_pkg::SUP_RETEST);

	genvar gi;
	generate
		for (gi = 0; gi < socket_pm_pkg::NUM_EVENTS; gi++)
		begin : g_event
			always_ff @(posedge sys_clk or negedge rstn)
			begin
				if (!rstn)
					ev_status_ff[gi] <= 1'b0;
				else if (clk_en)
				begin
					if (ev_set[gi])
						ev_status_ff[gi] <= 1'b1;
					else if (wr_status && reg_wdata[gi])
						ev_status_ff[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			ev_mask_ff <= socket_pm_pkg::RST_EVENT_MASK;
		else if (clk_en && wr_mask)
			ev_mask_ff <= reg_wdata[socket_pm_pkg::NUM_EVENTS-1:0];
	end

	assign irq = |(ev_status_ff & ev_mask_ff);

	// ------------------------------------------------------------
	// Read path, data valid the cycle after the strobe
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		case (reg_addr)
			socket_pm_pkg::OFS_SUPPLY_POLICY:
			begin
				// bits 31-8 and 3 stay zero
				nxt_rdata[socket_pm_pkg::VPP_LSB +: socket_pm_pkg::VPP_W] =
					vpp_req_ff;
				nxt_rdata[socket_pm_pkg::VCC_LSB +: socket_pm_pkg::VCC_W] =
					vcc_req_ff;
				nxt_rdata[socket_pm_pkg::HALT_POLICY_BIT] = halt_policy_ff;
			end
			socket_pm_pkg::OFS_IDLE_CLOCK:
			begin
				nxt_rdata[socket_pm_pkg::HALT_SLOW_BIT] = halt_slow_ff;
				nxt_rdata[socket_pm_pkg::GATE_ENABLE_BIT] = gate_enable_ff;
				nxt_rdata[socket_pm_pkg::RATE_CHANGED_BIT] =
					clock_rate_changed;
				nxt_rdata[socket_pm_pkg::ACCESS_SEEN_BIT] = access_seen_ff;
			end
			socket_pm_pkg::OFS_EVENT_STATUS:
				nxt_rdata[socket_pm_pkg::NUM_EVENTS-1:0] = ev_status_ff;
			socket_pm_pkg::OFS_EVENT_MASK:
				nxt_rdata[socket_pm_pkg::NUM_EVENTS-1:0] = ev_mask_ff;
			default:
				nxt_rdata = 32'h0000_0000;
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata_ff <= 32'h0000_0000;
		else if (clk_en)
			reg_rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
	end

	assign reg_rdata = reg_rdata_ff;

endmodule

// >>> dv/card_model.sv
// Card-side model: card clock source and card access pulses
`timescale 1ns/100ps
module card_model (
	input wire logic sys_clk,
	output logic card_clk,
	output logic card_access,
	output logic card_present
);
	bit run = 1'b1;

	initial
	begin
		card_clk = 1'b0;
		card_access = 1'b0;
		card_present = 1'b1;
		// Clock stands at its last level while stopped, as a real card would
		forever
		begin
			#40;
			if (run)
				card_clk = ~card_clk;
		end
	end

	task automatic access();
		@(posedge sys_clk);
		card_access <= 1'b1;
		@(posedge sys_clk);
		card_access <= 1'b0;
	endtask
endmodule

// >>> dv/socket_pm_checker.sv
// Port-level assertions for the socket supply and idle clock block
`timescale 1ns/100ps
module socket_pm_checker #(
	parameter int GAP_LIMIT = 32
)(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic card_present,
	input wire logic card_is_cardbus,
	input wire logic [7:0] vpp_levels_ok,
	input wire logic [7:0] vcc_levels_ok,
	input wire logic card_access,
	input wire logic socket_idle,
	input wire logic force_voltage_type,
	input wire logic card_voltage_retest,
	input wire logic interrogation_done,
	input wire logic interrogation_start,
	input wire logic [2:0] vpp_apply,
	input wire logic [2:0] vcc_apply,
	input wire logic supply_enabled,
	input wire logic clkrun_halt_permit,
	input wire logic clkrun_slow_permit
);
	logic [7:0] vpp_ok_ff;
	logic [7:0] vcc_ok_ff;
	logic pwr_ok_ff;

	// ------------------------------------------------------------
	// Inputs as the power switch saw them one edge earlier
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			vpp_ok_ff <= 8'h00;
			vcc_ok_ff <= 8'h00;
			pwr_ok_ff <= 1'b0;
		end
		else
		begin
			vpp_ok_ff <= vpp_levels_ok;
			vcc_ok_ff <= vcc_levels_ok;
			pwr_ok_ff <= card_present & card_is_cardbus & supply_enabled;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	// A frozen design owes no answer, so frozen cycles are not judged
	default disable iff (!rstn || !clk_en);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_permit_idle;
		(clkrun_halt_permit || clkrun_slow_permit) |-> socket_idle;
	endproperty
	a_permit_idle: assert property (p_permit_idle)
		else $error("clock permit without idle socket");
	property p_one_permit;
		!(clkrun_halt_permit && clkrun_slow_permit);
	endproperty
	a_one_permit: assert property (p_one_permit)
		else $error("halt and slow permitted together");
	property p_vpp_ok;
		vpp_apply != 3'h0 |-> pwr_ok_ff && vpp_ok_ff[vpp_apply];
	endproperty
	a_vpp_ok: assert property (p_vpp_ok)
		else $error("program voltage applied at unaccepted level");
	property p_vpp_rsv;
		vpp_apply < 3'h6;
	endproperty
	a_vpp_rsv: assert property (p_vpp_rsv)
		else $error("reserved program voltage code applied");
	property p_vcc_ok;
		vcc_apply != 3'h0 |-> pwr_ok_ff && vcc_ok_ff[vcc_apply];
	endproperty
	a_vcc_ok: assert property (p_vcc_ok)
		else $error("card supply applied at unaccepted level");
	property p_retest_start;
		card_voltage_retest |=> interrogation_start;
	endproperty
	a_retest_start: assert property (p_retest_start)
		else $error("retest did not start interrogation");
	property p_force_lock;
		force_voltage_type && !card_voltage_retest |=> !supply_enabled;
	endproperty
	a_force_lock: assert property (p_force_lock)
		else $error("forced voltage type left supply enabled");
	property p_reenable;
		$rose(supply_enabled) |-> $past(interrogation_done);
	endproperty
	a_reenable: assert property (p_reenable)
		else $error("supply enabled without interrogation done");
	property p_sup_rsv;
		$past(reg_rd && reg_addr == 8'h10) |->
			(reg_rdata & 32'hFFFF_FF08) == 32'h0000_0000;
	endproperty
	a_sup_rsv: assert property (p_sup_rsv)
		else $error("reserved supply bits read nonzero");
	property p_idle_rsv;
		$past(reg_rd && reg_addr == 8'h20) |->
			(reg_rdata & 32'hFCFE_FFFE) == 32'h0000_0000;
	endproperty
	a_idle_rsv: assert property (p_idle_rsv)
		else $error("reserved idle clock bits read nonzero");
	property p_acc_clear;
		$past(reg_rd && reg_addr == 8'h20) &&
			$past(reg_rd && reg_addr == 8'h20, 2) &&
			!$past(card_access, 2) |-> !reg_rdata[25];
	endproperty
	a_acc_clear: assert property (p_acc_clear)
		else $error("access flag survived a read");
endmodule

bind socket_power_clock_control socket_pm_checker #(
	.GAP_LIMIT(GAP_LIMIT)
) chk (
	.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.card_present(card_present), .card_is_cardbus(card_is_cardbus),
	.vpp_levels_ok(vpp_levels_ok), .vcc_levels_ok(vcc_levels_ok),
	.card_access(card_access), .socket_idle(socket_idle),
	.force_voltage_type(force_voltage_type),
	.card_voltage_retest(card_voltage_retest),
	.interrogation_done(interrogation_done),
	.interrogation_start(interrogation_start),
	.vpp_apply(vpp_apply), .vcc_apply(vcc_apply),
	.supply_enabled(supply_enabled),
	.clkrun_halt_permit(clkrun_halt_permit),
	.clkrun_slow_permit(clkrun_slow_permit)
);

// >>> dv/tb_top.sv
// Self-checking bench for the socket supply and idle clock block
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	logic sys_clk, rstn, reg_wr, reg_rd, card_clk, card_present;
	logic [7:0] reg_addr, vpp_ok, vcc_ok;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic card_is_cardbus, card_access, socket_idle, host_stop;
	logic force_vt, retest, intg_done, intg_start, sup_on, halt_p, slow_p;
	logic irq, clk_en;
	logic [2:0] vpp_apply, vcc_apply;
	int n_errors = 0;
	int total_checks = 0;
	int sup = 0, idl = 0, st = 0, sup_en = 1, ex;

	socket_power_clock_control #(.GAP_LIMIT(20)) uut (
		.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_clk(card_clk),
		.card_present(card_present), .card_is_cardbus(card_is_cardbus),
		.vpp_levels_ok(vpp_ok), .vcc_levels_ok(vcc_ok),
		.card_access(card_access), .socket_idle(socket_idle),
		.host_clk_stopping(host_stop), .force_voltage_type(force_vt),
		.card_voltage_retest(retest), .interrogation_done(intg_done),
		.interrogation_start(intg_start), .vpp_apply(vpp_apply),
		.vcc_apply(vcc_apply), .supply_enabled(sup_on),
		.clkrun_halt_permit(halt_p), .clkrun_slow_permit(slow_p),
		.irq(irq)
	);
	card_model card (.sys_clk(sys_clk), .card_clk(card_clk),
		.card_access(card_access), .card_present(card_present));

	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Bus tasks, each returns just after a rising edge
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		if (a == 8'h10 && sup_en != 0)
			sup = v & 32'hF7;
		if (a == 8'h20)
			idl = v & 32'h10001;
		if (a == 8'h40)
			st = st & ~v[3:0];
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge sys_clk);
	endtask

	task automatic chk_irq(input logic e);
		#1 `CHK(irq, e)
		@(posedge sys_clk);
	endtask

	task automatic end_sim();
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_errors++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(81));
		{rstn, reg_wr, reg_rd, socket_idle, host_stop} = '0;
		{force_vt, retest, intg_done} = '0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		{vpp_ok, vcc_ok} = '0;
		card_is_cardbus = 1'b1;
		clk_en = 1'b1;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		foreach (d[i])
			if (i < 5)
			begin
				rd(8'(8'h10 << (i % 3) | 8'h30 * (i / 3)), d);
				`CHK(d, 32'h0)
			end
		wr(8'h10, 32'hFFFF_FFFF);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h10, d);
		`CHK(d, sup)
		rd(8'h20, d);
		`CHK(d, idl)
		// Every combination of policy, gate, select and host clock state
		for (int i = 0; i < 16; i++)
		begin
			wr(8'h10, i[0] << 7);
			wr(8'h20, {15'h0, i[1], 15'h0, i[2]});
			socket_idle <= 1'($urandom);
			host_stop <= i[3];
			@(posedge sys_clk);
			#1 ex = idl[16] && socket_idle && (sup[7] || host_stop);
			`CHK(halt_p, ex && !idl[0])
			`CHK(slow_p, ex && idl[0])
			@(posedge sys_clk);
		end
		// Every program voltage code against random acceptance masks
		for (int c = 0; c < 8; c++)
		begin
			vpp_ok <= 8'($urandom);
			vcc_ok <= 8'($urandom);
			card_is_cardbus <= (c != 3);
			wr(8'h10, c | c << 4);
			rd(8'h10, d);
			`CHK(d, sup)
			ex = card_present && card_is_cardbus && sup_en != 0;
			`CHK(vpp_apply, (ex && c < 6 && vpp_ok[c]) ? c : 0)
			`CHK(vcc_apply, (ex && vcc_ok[c]) ? c : 0)
		end
		force_vt <= 1'b1;
		@(posedge sys_clk);
		force_vt <= 1'b0;
		#1 `CHK(sup_on, 1'b0)
		sup_en = 0;
		@(posedge sys_clk);
		wr(8'h10, 32'h33);
		rd(8'h10, d);
		`CHK(d, sup)
		`CHK(vpp_apply, 3'h0)
		retest <= 1'b1;
		@(posedge sys_clk);
		retest <= 1'b0;
		#1 `CHK(intg_start, 1'b1)
		@(posedge sys_clk);
		intg_done <= 1'b1;
		@(posedge sys_clk);
		intg_done <= 1'b0;
		#1 `CHK(sup_on, 1'b1)
		sup_en = 1;
		st = st | 8;
		@(posedge sys_clk);
		// Access flag, masked event, then back-to-back reads
		wr(8'h44, 32'h0);
		card.access();
		st = st | 1;
		chk_irq(1'b0);
		reg_addr <= 8'h20;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		#1 `CHK(reg_rdata, idl | 32'h0200_0000)
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, idl)
		@(posedge sys_clk);
		wr(8'h44, 32'h1);
		chk_irq(1'b1);
		rd(8'h40, d);
		`CHK(d, st)
		wr(8'h40, 32'h1);
		chk_irq(1'b0);
		// Card clock stopped, then resumed
		card.run = 1'b0;
		repeat (40) @(posedge sys_clk);
		rd(8'h20, d);
		`CHK(d, idl | 32'h0100_0000)
		card.run = 1'b1;
		repeat (24) @(posedge sys_clk);
		rd(8'h20, d);
		`CHK(d, idl)
		rd(8'h40, d);
		st = st | 6;
		`CHK(d, st)
		// Clock enable low keeps the idle clock register from taking a write
		ex = idl;
		clk_en <= 1'b0;
		wr(8'h20, 32'h0);
		idl = ex;
		clk_en <= 1'b1;
		rd(8'h20, d);
		`CHK(d, idl)
		end_sim();
	end
endmodule
